//--- verilog/udmc_regs.svh
// Register offsets, field positions, reset values and timing counts of the USB module control block.
`ifndef UDMC_REGS_SVH
`define UDMC_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------------------
`define UDMC_ADDR_W          8
`define UDMC_OFS_CTRL        8'h00
`define UDMC_OFS_CFG         8'h04
`define UDMC_OFS_XSTAT       8'h08
`define UDMC_OFS_EVT         8'h0c
`define UDMC_OFS_EP_BASE     8'h10
`define UDMC_NUM_EP          8

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define UDMC_CTRL_PPRST      1
`define UDMC_CTRL_SE0        5
`define UDMC_CTRL_PKTOFF     4
`define UDMC_CTRL_MODEN      3
`define UDMC_CTRL_RESUME     2
`define UDMC_CTRL_SUSP       0
`define UDMC_CTRL_RESET      8'h00

// ----------------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------------
`define UDMC_CFG_PPB_LO      0
`define UDMC_CFG_PULLUP      4
`define UDMC_CFG_RESET       8'h00
`define UDMC_PPB_NONE        2'h0

// ----------------------------------------------------------------------------
// Event register fields (transaction done flag)
// ----------------------------------------------------------------------------
`define UDMC_EVT_TRN         3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define UDMC_CLK_HZ          25000000
`define UDMC_RESUME_MS       10
`define UDMC_RESUME_CYC      ((`UDMC_CLK_HZ / 1000) * `UDMC_RESUME_MS)
`define UDMC_FIFO_DEPTH      4

`endif

//--- verilog/udmc_pkg.sv
// Types shared by the USB module control block.
package udmc_pkg;

    // Event reported by the engine when a transaction finishes.
    typedef struct packed {
        logic [3:0] endpoint_number_field;
        logic       dir_in;
        logic       pingpong_indicator;
    } udmc_stat_s;

    // Bus-side line state after synchronisation.
    typedef struct packed {
        logic dp;
        logic dm;
    } udmc_line_s;

    // Resume signalling sequencer.
    typedef enum logic [1:0] {
        UDMC_RS_IDLE = 2'b00,
        UDMC_RS_DRIVE = 2'b01,
        UDMC_RS_HOLD = 2'b10
    } udmc_rs_e;

endpackage

//--- verilog/udmc_stat_fifo.sv
// Four-entry transfer status FIFO read through the transfer status register.
`include "udmc_regs.svh"

module udmc_stat_fifo #(
    parameter int DEPTH = `UDMC_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                clk_sys_i,
    input  wire logic                sys_rst_i,
    // Write side from the engine
    input  wire logic                push_i,
    input  wire udmc_pkg::udmc_stat_s push_data_i,
    output logic                     full_o,
    // Read side towards the register window
    input  wire logic                pop_i,
    output logic                     valid_o,
    output udmc_pkg::udmc_stat_s     head_o
);

    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 2");
    end

    udmc_pkg::udmc_stat_s mem_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0]   cnt_r;
    wire           do_push = push_i && !full_o;
    wire           do_pop  = pop_i && valid_o;

    assign full_o  = (cnt_r == (PW+1)'(DEPTH));
    assign valid_o = (cnt_r != '0);
    assign head_o  = mem_r[rp_r];

    // Storage is not reset; only the pointers need a defined value.
    always_ff @(posedge clk_sys_i) begin
        if (do_push)
            mem_r[wp_r] <= push_data_i;
    end

    // Pointers and fill count; push and pop may coincide.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (do_push)
                wp_r <= wp_r + 1'b1;
            if (do_pop)
                rp_r <= rp_r + 1'b1;
            cnt_r <= cnt_r + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end

endmodule

//--- verilog/udmc_ctrl.sv
// USB device module control: enable, attach, ping-pong reset, packet disable, resume and suspend.
// ----------------------------------------------------------------------------
// Summary of operation
// - Status bit shows single-ended zero on bus while enabled.
// - Enable activates engine, clears ping-pong indicators.
// - Enable turns on pull-ups when the pull-up bit is configured: soft attach.
// - Pointer reset forces all pointers to even.
// - Pointer reset stays until firmware clears it.
// - Pointer reset ignored without ping-pong mode.
// - SETUP token sets packet disable, halts traffic.
// - Software only clears packet disable; resumes traffic.
// - Pending events stay readable in status FIFO.
// - Resume bit set while enabled drives resume signalling until cleared; 10 ms minimum counted.
// - Suspend gates engine clock, low power.
// - Suspended device stays attached, transceiver idle except while driving resume.
// - Eight independent endpoint control registers.
// - Status register windows four-entry FIFO; clear advances.
// - Pull-ups only when enabled and configured.
// ----------------------------------------------------------------------------
//
// The plain strobed port and the register offsets are this design's own decisions.
`include "udmc_regs.svh"

module udmc_ctrl #(
    parameter int NUM_EP     = `UDMC_NUM_EP,
    parameter int RESUME_CYC = `UDMC_RESUME_CYC
) (
    // Clock and reset
    input  wire logic                     clk_sys_i,
    input  wire logic                     sys_rst_i,
    // Register port
    input  wire logic [`UDMC_ADDR_W-1:0]  reg_addr_i,
    input  wire logic [7:0]               reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    output logic      [7:0]               reg_rdata_o,
    // Bus line pins (asynchronous)
    input  wire logic                     usb_dp_i,
    input  wire logic                     usb_dm_i,
    // Engine side
    input  wire logic                     setup_rx_i,
    input  wire logic                     trn_done_i,
    input  wire udmc_pkg::udmc_stat_s     trn_stat_i,
    output logic                          stat_full_o,
    output logic                          engine_en_o,
    output logic                          engine_clk_en_o,
    output logic                          pkt_allow_o,
    output logic                          ppind_clear_o,
    output logic                          pp_force_even_o,
    output logic [8*NUM_EP-1:0]           ep_ctrl_o,
    // Transceiver side
    output logic                          pullup_en_o,
    output logic                          xcvr_idle_o,
    output logic                          low_power_o,
    output logic                          resume_drive_o
);

    // Refuse what the decode cannot serve.
    if (NUM_EP < 1 || NUM_EP > 8) begin : g_bad_ep
        $error("NUM_EP must be 1 to 8");
    end
    if (RESUME_CYC < 1) begin : g_bad_resume
        $error("RESUME_CYC must be at least 1");
    end

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    // Endpoint decode is needed for both reads and writes.
    function automatic logic ep_hit(input logic [`UDMC_ADDR_W-1:0] a, input int n);
        ep_hit = (a == `UDMC_ADDR_W'(`UDMC_OFS_EP_BASE + 4 * n));
    endfunction

    // One select per register address.
    wire hit_ctrl  = (reg_addr_i == `UDMC_OFS_CTRL);
    wire hit_cfg   = (reg_addr_i == `UDMC_OFS_CFG);
    wire hit_xstat = (reg_addr_i == `UDMC_OFS_XSTAT);
    wire hit_evt   = (reg_addr_i == `UDMC_OFS_EVT);
    wire wr_ctrl   = reg_wr_i && hit_ctrl;
    wire wr_cfg    = reg_wr_i && hit_cfg;
    wire wr_evt    = reg_wr_i && hit_evt;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    // The bus lines are asynchronous.
    udmc_pkg::udmc_line_s line_m_r;
    udmc_pkg::udmc_line_s line_r;

    // The first stage is read only by the second stage.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            line_m_r <= '0;
            line_r   <= '0;
        end else begin
            line_m_r <= '{dp: usb_dp_i, dm: usb_dm_i};
            line_r   <= line_m_r;
        end
    end

    // ------------------------------------------------------------------------
    // Control and configuration registers
    // ------------------------------------------------------------------------
    // Software-visible control state.
    logic       moden_r;
    logic       pprst_r;
    logic       pktoff_r;
    logic       resume_r;
    logic       susp_r;
    logic [7:0] cfg_r;
    logic [7:0] ep_r [NUM_EP];
    logic       se0_r;

    // The enable edge comes from the write.
    wire moden_rise = wr_ctrl && reg_wdata_i[`UDMC_CTRL_MODEN] && !moden_r;

    // A written one is ignored; setup wins.
    wire pktoff_nxt = setup_rx_i ? 1'b1 :
                      (wr_ctrl && !reg_wdata_i[`UDMC_CTRL_PKTOFF]) ? 1'b0 : pktoff_r;

    // Software holds enable, pointer reset, resume and suspend; packet
    // disable can only be cleared from software and the engine's set wins.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            moden_r  <= 1'b0;
            pprst_r  <= 1'b0;
            pktoff_r <= 1'b0;
            resume_r <= 1'b0;
            susp_r   <= 1'b0;
            cfg_r    <= `UDMC_CFG_RESET;
        end else begin
            pktoff_r <= pktoff_nxt;
            if (wr_ctrl) begin
                moden_r  <= reg_wdata_i[`UDMC_CTRL_MODEN];
                pprst_r  <= reg_wdata_i[`UDMC_CTRL_PPRST];
                resume_r <= reg_wdata_i[`UDMC_CTRL_RESUME];
                susp_r   <= reg_wdata_i[`UDMC_CTRL_SUSP];
            end
            if (wr_cfg)
                cfg_r <= reg_wdata_i;
        end
    end

    // Each endpoint has its own register.
    // Slots past NUM_EP are never decoded.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EP; gi++) begin : g_ep
            always_ff @(posedge clk_sys_i) begin
                if (sys_rst_i)
                    ep_r[gi] <= 8'h00;
                else if (reg_wr_i && ep_hit(reg_addr_i, gi))
                    ep_r[gi] <= reg_wdata_i;
            end
            assign ep_ctrl_o[8*gi +: 8] = ep_r[gi];
        end
    endgenerate

    // Single-ended zero is sampled live every cycle, no acknowledge needed.
    // It reads as zero while disabled.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i)
            se0_r <= 1'b0;
        else
            se0_r <= moden_r && !line_r.dp && !line_r.dm;
    end

    // ------------------------------------------------------------------------
    // Transfer status FIFO and transaction done flag
    // ------------------------------------------------------------------------
    // The head is what the status window shows.
    udmc_pkg::udmc_stat_s head;
    logic                 head_valid;
    logic                 trn_flag_r;
    // Writing one to the flag does nothing.
    wire trn_clear = wr_evt && !reg_wdata_i[`UDMC_EVT_TRN];
    wire fifo_pop  = trn_clear && trn_flag_r;

    // Events stay queued even while packet transfers are disabled.
    udmc_stat_fifo #(
        .DEPTH (`UDMC_FIFO_DEPTH)
    ) u_stat_fifo (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .push_i      (trn_done_i),
        .push_data_i (trn_stat_i),
        .full_o      (stat_full_o),
        .pop_i       (fifo_pop),
        .valid_o     (head_valid),
        .head_o      (head)
    );

    // The flag drops for one cycle after a pop, then reasserts if another entry waits.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i)
            trn_flag_r <= 1'b0;
        else if (fifo_pop)
            trn_flag_r <= 1'b0;
        else
            trn_flag_r <= head_valid;
    end

    // ------------------------------------------------------------------------
    // Resume signalling
    // ------------------------------------------------------------------------
    udmc_pkg::udmc_rs_e rs_r;
    udmc_pkg::udmc_rs_e rs_nxt;
    logic [31:0]        rs_cnt_r;
    wire                rs_done = (rs_cnt_r == 32'(RESUME_CYC - 1));

    // Drive resume while the bit is set; the counter reports when the
    // minimum time has elapsed, software still ends it by clearing the bit.
    // Driving starts only while enabled.
    always_comb begin
        rs_nxt = rs_r;
        case (rs_r)
            udmc_pkg::UDMC_RS_IDLE:  if (resume_r && moden_r) rs_nxt = udmc_pkg::UDMC_RS_DRIVE;
            udmc_pkg::UDMC_RS_DRIVE: if (!resume_r) rs_nxt = udmc_pkg::UDMC_RS_IDLE;
                                     else if (rs_done) rs_nxt = udmc_pkg::UDMC_RS_HOLD;
            udmc_pkg::UDMC_RS_HOLD:  if (!resume_r) rs_nxt = udmc_pkg::UDMC_RS_IDLE;
            default:                 rs_nxt = udmc_pkg::UDMC_RS_IDLE;
        endcase
    end

    // The counter runs only while driving.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rs_r     <= udmc_pkg::UDMC_RS_IDLE;
            rs_cnt_r <= 32'h0;
        end else begin
            rs_r     <= rs_nxt;
            rs_cnt_r <= (rs_r == udmc_pkg::UDMC_RS_DRIVE) ? rs_cnt_r + 32'h1 : 32'h0;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs towards engine and transceiver
    // ------------------------------------------------------------------------
    // Any buffering mode but none uses ping-pong.
    wire pp_mode = (cfg_r[`UDMC_CFG_PPB_LO +: 2] != `UDMC_PPB_NONE);
    logic ppind_clear_r;

    // One-cycle pulse in the same cycle that the enable rises.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i)
            ppind_clear_r <= 1'b0;
        else
            ppind_clear_r <= moden_rise;
    end

    // Engine gating from enable and suspend.
    assign engine_en_o     = moden_r;
    assign ppind_clear_o   = ppind_clear_r;
    assign pp_force_even_o = pprst_r && pp_mode;
    assign pkt_allow_o     = moden_r && !pktoff_r && !susp_r;
    // Pull-ups stay on through suspend so the host sees no detach.
    assign pullup_en_o     = moden_r && cfg_r[`UDMC_CFG_PULLUP];
    assign engine_clk_en_o = moden_r && !susp_r;
    assign low_power_o     = susp_r;
    assign xcvr_idle_o     = susp_r && (rs_r == udmc_pkg::UDMC_RS_IDLE);
    assign resume_drive_o  = (rs_r != udmc_pkg::UDMC_RS_IDLE);

    // ------------------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------------------
    // Unmapped addresses read zero; unmapped configuration bits read back as written.
    logic [7:0] rd_mux;
    wire  [7:0] ctrl_view = {2'b00, se0_r, pktoff_r, moden_r, resume_r, pprst_r, susp_r};
    wire  [7:0] stat_view = {2'b00, head.endpoint_number_field, head.dir_in, head.pingpong_indicator};
    wire  [7:0] evt_view  = {4'h0, trn_flag_r, 3'h0};

    always_comb begin
        rd_mux = 8'h00;
        if (hit_ctrl)
            rd_mux = ctrl_view;
        else if (hit_cfg)
            rd_mux = cfg_r;
        else if (hit_xstat)
            rd_mux = stat_view;
        else if (hit_evt)
            rd_mux = evt_view;
        for (int i = 0; i < NUM_EP; i++) begin
            if (ep_hit(reg_addr_i, i))
                rd_mux = ep_r[i];
        end
    end

    // Zero between reads hides stale data.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i)
            reg_rdata_o <= 8'h00;
        else
            reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
    end

endmodule

//--- dv/udmc_ctrl_monitor.sv
// Concurrent checks on the ports of the USB module control block.
`include "udmc_regs.svh"

module udmc_ctrl_monitor #(
    parameter int NUM_EP = `UDMC_NUM_EP
) (
    // Clock and reset
    input wire logic                    clk_sys_i,
    input wire logic                    sys_rst_i,
    // Register port and engine event
    input wire logic [`UDMC_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0]              reg_wdata_i,
    input wire logic                    reg_wr_i,
    input wire logic                    setup_rx_i,
    // Outputs under watch
    input wire logic                    engine_en_o,
    input wire logic                    engine_clk_en_o,
    input wire logic                    pkt_allow_o,
    input wire logic                    ppind_clear_o,
    input wire logic                    pp_force_even_o,
    input wire logic [8*NUM_EP-1:0]     ep_ctrl_o,
    input wire logic                    pullup_en_o,
    input wire logic                    xcvr_idle_o,
    input wire logic                    low_power_o,
    input wire logic                    resume_drive_o
);
    // ------------------------------------------------------------------------
    // Decodes and sequences
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    // Write decodes shared by several properties.
    wire ctrl_wr = reg_wr_i && (reg_addr_i == `UDMC_OFS_CTRL);
    wire cfg_wr  = reg_wr_i && (reg_addr_i == `UDMC_OFS_CFG);
    wire ep0_wr  = reg_wr_i && (reg_addr_i == `UDMC_OFS_EP_BASE);

    // The indicator clear must be a single pulse, so a stuck clear shows up.
    sequence s_clear_pulse;
        ##[0:1] ppind_clear_o ##1 !ppind_clear_o;
    endsequence

    a_clk_gate_on: assert property (engine_clk_en_o == (engine_en_o && !low_power_o))
        else $error("engine clock enable does not follow enable and suspend");
    a_pkt_gate_on: assert property (pkt_allow_o |-> engine_en_o && !low_power_o)
        else $error("packets allowed while disabled or suspended");
    a_setup_halts_pkt: assert property (setup_rx_i |=> !pkt_allow_o)
        else $error("setup token did not halt packet transfers");
    a_pkt_no_set: assert property (pkt_allow_o && !setup_rx_i |=> pkt_allow_o || !engine_en_o || low_power_o)
        else $error("packet disable set without a setup token");
    a_pkt_clear_resume: assert property (ctrl_wr && reg_wdata_i[4:0] == 5'h08 && !setup_rx_i |=> pkt_allow_o)
        else $error("clearing packet disable did not resume transfers");
    a_ppind_clear_once: assert property ($rose(engine_en_o) |-> s_clear_pulse)
        else $error("indicator clear pulse missing after enable");
    a_pullup_gate_on: assert property (pullup_en_o |-> engine_en_o)
        else $error("pull-up on while module disabled");
    a_force_even_hold: assert property (pp_force_even_o && !ctrl_wr && !cfg_wr |=> pp_force_even_o)
        else $error("pointer reset cleared itself");
    a_force_even_drop: assert property (ctrl_wr && !reg_wdata_i[1] |=> !pp_force_even_o)
        else $error("pointers still forced after reset bit cleared");
    a_suspend_xcvr_idle: assert property (low_power_o && !resume_drive_o |-> xcvr_idle_o)
        else $error("transceiver not idle in suspend");
    a_ep_write_lands: assert property (ep0_wr |=> ep_ctrl_o[7:0] == $past(reg_wdata_i))
        else $error("endpoint register did not take the written value");
endmodule

//--- dv/udmc_host_model.sv
// Bus-side host model: holds the lines idle or drives a single-ended zero.
module udmc_host_model (
    // Request from the bench
    input  wire logic se0_req_i,
    // Bus lines towards the device
    output logic      dp_o,
    output logic      dm_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle is the J state (plus line high); a bus reset pulls both lines low.
    assign dp_o = !se0_req_i;
    assign dm_o = 1'b0;
endmodule

//--- dv/udmc_ctrl_bench.sv
// Self-checking bench for the USB module control block.
`include "udmc_regs.svh"

module udmc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    logic                 clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, setup_rx_i, trn_done_i, se0_req;
    logic [7:0]           reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic                 usb_dp_i, usb_dm_i, stat_full_o, engine_en_o, engine_clk_en_o, pkt_allow_o;
    logic                 ppind_clear_o, pp_force_even_o, pullup_en_o, xcvr_idle_o, low_power_o, resume_drive_o;
    logic [63:0]          ep_ctrl_o, exp_ep;
    udmc_pkg::udmc_stat_s trn_stat_i;
    int                   fail_count, n_checks, n_pulse;

    udmc_ctrl #(.NUM_EP(8), .RESUME_CYC(8)) dut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .usb_dp_i(usb_dp_i),
        .usb_dm_i(usb_dm_i), .setup_rx_i(setup_rx_i), .trn_done_i(trn_done_i), .trn_stat_i(trn_stat_i),
        .stat_full_o(stat_full_o), .engine_en_o(engine_en_o), .engine_clk_en_o(engine_clk_en_o),
        .pkt_allow_o(pkt_allow_o), .ppind_clear_o(ppind_clear_o), .pp_force_even_o(pp_force_even_o),
        .ep_ctrl_o(ep_ctrl_o), .pullup_en_o(pullup_en_o), .xcvr_idle_o(xcvr_idle_o),
        .low_power_o(low_power_o), .resume_drive_o(resume_drive_o));

    udmc_host_model host (.se0_req_i(se0_req), .dp_o(usb_dp_i), .dm_o(usb_dm_i));

    // ------------------------------------------------------------------------
    // Clock, pulse counter and watchdog
    // ------------------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    // Counting clear pulses lets the bench see a pulse that repeats or never comes.
    always @(posedge clk_sys_i) if (ppind_clear_o === 1'b1) n_pulse++;

    // The tests need well under a thousand cycles; five thousand means a hang.
    initial begin
        #(40 * 5000);
        fail_count++;
        stop_test();
    end

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // A write ends at the falling edge so that register-driven outputs have settled.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        @(negedge clk_sys_i);
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(64'(reg_rdata_o), 64'(exp));
    endtask

    task automatic stop_test();
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        sys_rst_i = 1'b1;
        {reg_wr_i, reg_rd_i, setup_rx_i, trn_done_i, se0_req} = 5'h00;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        trn_stat_i = '0;
        exp_ep = 64'h0;
        repeat (20) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rchk(`UDMC_OFS_CTRL, `UDMC_CTRL_RESET);
        chk(pullup_en_o, 1'b0);
        // Configure ping-pong mode and pull-ups, then attach.
        wr(`UDMC_OFS_CFG, 8'h11);
        wr(`UDMC_OFS_CTRL, 8'h08);
        repeat (2) @(negedge clk_sys_i);
        chk({engine_en_o, pullup_en_o, pkt_allow_o}, 3'h7);
        chk(n_pulse, 1);
        // Pointer reset holds until firmware clears it, and only in ping-pong mode.
        wr(`UDMC_OFS_CTRL, 8'h0a);
        repeat (6) @(negedge clk_sys_i);
        chk(pp_force_even_o, 1'b1);
        rchk(`UDMC_OFS_CTRL, 8'h0a);
        wr(`UDMC_OFS_CTRL, 8'h08);
        chk(pp_force_even_o, 1'b0);
        wr(`UDMC_OFS_CFG, 8'h10);
        wr(`UDMC_OFS_CTRL, 8'h0a);
        chk(pp_force_even_o, 1'b0);
        wr(`UDMC_OFS_CTRL, 8'h08);
        // Single-ended zero from the host shows in the flag and goes again.
        se0_req <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        rchk(`UDMC_OFS_CTRL, 8'h28);
        se0_req <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        rchk(`UDMC_OFS_CTRL, 8'h08);
        // A setup token halts traffic; a written 1 never sets the flag.
        wr(`UDMC_OFS_CTRL, 8'h18);
        rchk(`UDMC_OFS_CTRL, 8'h08);
        @(posedge clk_sys_i);
        setup_rx_i <= 1'b1;
        @(posedge clk_sys_i);
        setup_rx_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(pkt_allow_o, 1'b0);
        rchk(`UDMC_OFS_CTRL, 8'h18);
        // Events pushed while halted stay queued; the fifth finds the queue full.
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys_i);
            trn_done_i <= 1'b1;
            trn_stat_i <= udmc_pkg::udmc_stat_s'({4'(i + 1), i[0], ~i[0]});
            @(posedge clk_sys_i);
            trn_done_i <= 1'b0;
        end
        @(negedge clk_sys_i);
        chk(stat_full_o, 1'b1);
        wr(`UDMC_OFS_CTRL, 8'h08);
        chk(pkt_allow_o, 1'b1);
        for (int i = 0; i < 4; i++) begin
            repeat (4) @(posedge clk_sys_i);
            rchk(`UDMC_OFS_EVT, 8'h08);
            rchk(`UDMC_OFS_XSTAT, {2'b00, 4'(i + 1), i[0], ~i[0]});
            wr(`UDMC_OFS_EVT, 8'h00);
        end
        repeat (4) @(posedge clk_sys_i);
        rchk(`UDMC_OFS_EVT, 8'h00);
        // Eight endpoint registers hold their own values; the next slot is unmapped.
        for (int n = 0; n < 8; n++) begin
            wr(8'(`UDMC_OFS_EP_BASE + 4 * n), 8'(8'h21 + 8'(n * 17)));
            exp_ep[8*n+:8] = 8'(8'h21 + 8'(n * 17));
        end
        for (int n = 0; n < 8; n++) rchk(8'(`UDMC_OFS_EP_BASE + 4 * n), exp_ep[8*n+:8]);
        chk(ep_ctrl_o, exp_ep);
        wr(8'h30, 8'h5a);
        rchk(8'h30, 8'h00);
        // Resume signalling lasts as long as firmware holds the bit.
        wr(`UDMC_OFS_CTRL, 8'h0c);
        repeat (2) @(negedge clk_sys_i);
        chk(resume_drive_o, 1'b1);
        repeat (20) @(negedge clk_sys_i);
        chk(resume_drive_o, 1'b1);
        wr(`UDMC_OFS_CTRL, 8'h08);
        repeat (3) @(negedge clk_sys_i);
        chk(resume_drive_o, 1'b0);
        // Suspend gates the engine clock but keeps the device attached.
        wr(`UDMC_OFS_CTRL, 8'h09);
        chk({low_power_o, engine_clk_en_o, pkt_allow_o, xcvr_idle_o, pullup_en_o}, 5'h13);
        wr(`UDMC_OFS_CTRL, 8'h08);
        chk({low_power_o, engine_clk_en_o, xcvr_idle_o, pullup_en_o}, 4'h5);
        // Clearing the enable detaches from the bus.
        wr(`UDMC_OFS_CTRL, 8'h00);
        chk({engine_en_o, pullup_en_o}, 2'h0);
        chk(n_pulse, 1);
        stop_test();
    end
endmodule

bind udmc_ctrl udmc_ctrl_monitor #(.NUM_EP(NUM_EP)) u_mon (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .setup_rx_i(setup_rx_i), .engine_en_o(engine_en_o), .engine_clk_en_o(engine_clk_en_o),
    .pkt_allow_o(pkt_allow_o), .ppind_clear_o(ppind_clear_o), .pp_force_even_o(pp_force_even_o),
    .ep_ctrl_o(ep_ctrl_o), .pullup_en_o(pullup_en_o), .xcvr_idle_o(xcvr_idle_o), .low_power_o(low_power_o),
    .resume_drive_o(resume_drive_o));
